/* tcso_defs.vh */
// Purpose: constants of the timer/counter with secondary oscillator
// Assumes: 8-bit register port, 3-bit register address
// Notes: included by tcso_timer.v
`ifndef TCSO_DEFS_VH
`define TCSO_DEFS_VH
// register addresses
`define TCSO_A_CTRL      3'h0
`define TCSO_A_GATE      3'h1
`define TCSO_A_LOW       3'h2
`define TCSO_A_HIGH      3'h3
`define TCSO_A_COMP      3'h4
`define TCSO_A_OSC       3'h5
`define TCSO_A_OSC2      3'h6
`define TCSO_A_PORT      3'h7
// counter_control fields
`define TCSO_B_SRC_HI    7
`define TCSO_B_SRC_LO    6
`define TCSO_B_PS_HI     5
`define TCSO_B_PS_LO     4
`define TCSO_B_SEC_OSC_ENABLE    3
`define TCSO_B_SYNCBYP   2
`define TCSO_B_WIDE      1
`define TCSO_B_ON        0
// gate_control fields
`define TCSO_B_GATE_EN   7
`define TCSO_B_GATE_POL  6
// osc_control / osc_control_two fields
`define TCSO_B_IDLE      7
`define TCSO_B_SCS_HI    1
`define TCSO_B_SCS_LO    0
`define TCSO_B_RUNFLAG   6
`define TCSO_B_WARMUP    3
// encodings
`define TCSO_SRC_INSTR   2'h0
`define TCSO_SRC_SYS     2'h1
`define TCSO_SRC_EXT     2'h2
`define TCSO_SCS_SEC     2'h1
// reset values
`define TCSO_RST_BYTE    8'h00
`define TCSO_RST_DIR     2'h3
// instruction clock is one in four system clocks
`define TCSO_INSTR_DIV   2'h3
`endif

/* tcso_timer.v */
// Purpose: 16-bit timer/counter with prescaler, external input and
//          secondary oscillator control
// Assumes: one clock CLOCK at 40 MHz; register port read data one cycle late
// Notes: the secondary oscillator arrives as a digital clock pin and is
//        sampled like any other pin
// Contract
// - count is a 16-bit incrementing low/high byte pair visible to software
// - internal source makes a timer advancing per instruction cycle (00) or system clock (01) after prescaler
// - count only when counter on and gate enable setting both permit it
// - crystal mode forces both oscillator pins to inputs, read as zero
// - source 01 system clock, 00 instruction clock, 10 pin or oscillator
// - internal source advances at multiples of system clock set by prescaler
// - prescale ratio 00 /1, 01 /2, 10 /4, 11 /8
// - external source increments once per 1, 2, 4 or 8 rising edges of external clock, as the prescaler selects
// - external input may be synchronized or used unsynchronized as configured
// - bypass bit 1 skips synchronizer, 0 synchronizes; ignored for internal source
// - synchronizer stops in sleep; only unsynchronized external keeps counting
// - counter mode needs a falling edge before first counted rising edge
// - wide mode maps high address to buffer, loaded on every low read
// - wide mode moves buffer into live high byte on low write
// - wide mode blocks direct access to live high byte
// - narrow mode reads and writes the two bytes independently
// - low byte write clears prescaler; high byte write leaves it
// - oscillator on by either enable bit, warm-up request or clock select 01
// - warm-up request starts oscillator ahead of any peripheral request
// - oscillator keeps running in every power-managed mode once enabled
// - clock select 01 enters secondary run mode for CPU and peripherals unless FAILSAFE is set
// - sleep in secondary run with idle control clear enters secondary idle
// - running flag set while oscillator supplies system clock, else clear
// - count rolls from FFFFh to 0000h and flags the overflow
`timescale 1ns/1ps
`include "tcso_defs.vh"

module tcso_timer #(
   parameter CNT_W = 16
) (
   input  wire       CLOCK,
   input  wire       RESETN,
   input  wire [2:0] ADDR,
   input  wire [7:0] WDATA,
   input  wire       WR,
   input  wire       RD,
   output reg  [7:0] RDATA,
   input  wire       EXT_COUNT_IN,
   input  wire       SEC_OSC_CLK_IN,
   input  wire       GATE_IN,
   input  wire       CRYSTAL_MODE,
   input  wire       SLEEP_EXEC,
   input  wire       WAKE,
   input  wire       FAILSAFE,
   input  wire [1:0] PORT_C_IN,
   output reg  [1:0] PORT_C_OUT,
   output wire [1:0] PORT_C_OE_N,
   output wire       SEC_OSC_ENABLE,
   output reg        SEC_CLOCK_RUNNING,
   output reg        SECONDARY_RUN_MODE,
   output reg        SECONDARY_IDLE_MODE,
   output reg        IN_SLEEP,
   output reg        OVERFLOW
);

   // ************************************************************
   // registers and pin samplers
   // ************************************************************
   reg  [7:0]       ctrl_r;
   reg  [7:0]       gate_r;
   reg  [7:0]       comp_r;
   reg  [7:0]       osc_r;
   reg              warmup_r;
   reg  [1:0]       dir_r;
   reg  [CNT_W-1:0] cnt_r;
   reg  [7:0]       hbuf_r;
   reg  [2:0]       ps_r;
   reg  [1:0]       div_r;
   reg              armed_r;
   reg              ext_d_r;
   reg              sync_tick_r;
   reg  [1:0]       ext_s_r;
   reg  [1:0]       osc_s_r;
   reg  [1:0]       gate_s_r;
   reg  [1:0]       pc0_s_r;
   reg  [1:0]       pc1_s_r;
   reg  [1:0]       crys_s_r;
   reg  [1:0]       fs_s_r;

   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ext_s_r  <= 2'h0;
         osc_s_r  <= 2'h0;
         gate_s_r <= 2'h0;
         pc0_s_r  <= 2'h0;
         pc1_s_r  <= 2'h0;
         crys_s_r <= 2'h0;
         fs_s_r   <= 2'h0;
      end else begin
         ext_s_r  <= {ext_s_r[0], EXT_COUNT_IN};
         osc_s_r  <= {osc_s_r[0], SEC_OSC_CLK_IN};
         gate_s_r <= {gate_s_r[0], GATE_IN};
         pc0_s_r  <= {pc0_s_r[0], PORT_C_IN[0]};
         pc1_s_r  <= {pc1_s_r[0], PORT_C_IN[1]};
         crys_s_r <= {crys_s_r[0], CRYSTAL_MODE};
         fs_s_r   <= {fs_s_r[0], FAILSAFE};
      end
   end

   // ************************************************************
   // decode
   // ************************************************************
   wire [1:0] src     = ctrl_r[`TCSO_B_SRC_HI:`TCSO_B_SRC_LO];
   wire [1:0] ps_sel  = ctrl_r[`TCSO_B_PS_HI:`TCSO_B_PS_LO];
   wire       wide    = ctrl_r[`TCSO_B_WIDE];
   wire       run_on  = ctrl_r[`TCSO_B_ON];
   wire       bypass  = ctrl_r[`TCSO_B_SYNCBYP];
   wire [1:0] system_clock_select     = osc_r[`TCSO_B_SCS_HI:`TCSO_B_SCS_LO];
   wire       crystal = crys_s_r[1];
   wire       is_ext  = (src == `TCSO_SRC_EXT);
   wire       wr_low  = WR && (ADDR == `TCSO_A_LOW);
   wire       wr_high = WR && (ADDR == `TCSO_A_HIGH);
   wire       rd_low  = RD && (ADDR == `TCSO_A_LOW);

   // external clock: pin, or oscillator when its enable bit is set
   wire ext_lvl = ctrl_r[`TCSO_B_SEC_OSC_ENABLE] ? osc_s_r[1] : ext_s_r[1];
   wire ext_rise = ext_lvl && !ext_d_r;
   wire ext_fall = !ext_lvl && ext_d_r;

   // gate level after polarity
   wire gate_ok = !gate_r[`TCSO_B_GATE_EN] ||
                  (gate_s_r[1] == gate_r[`TCSO_B_GATE_POL]);
   wire count_en = run_on && gate_ok;

   // ************************************************************
   // oscillator enable and power modes
   // ************************************************************
   assign SEC_OSC_ENABLE = ctrl_r[`TCSO_B_SEC_OSC_ENABLE] || comp_r[`TCSO_B_SEC_OSC_ENABLE] ||
                           warmup_r || (system_clock_select == `TCSO_SCS_SEC);
   // the enable ignores IN_SLEEP and idle so the oscillator keeps running

   assign PORT_C_OE_N = crystal ? 2'h3 : dir_r;

   wire sleeping = IN_SLEEP || SECONDARY_IDLE_MODE;

   // ************************************************************
   // raw clock tick per source
   // ************************************************************
   reg raw_tick;
   always @* begin
      case (src)
         `TCSO_SRC_SYS:   raw_tick = !sleeping;
         `TCSO_SRC_INSTR: raw_tick = !sleeping &&
                                     (div_r == `TCSO_INSTR_DIV);
         `TCSO_SRC_EXT:   raw_tick = ext_rise && armed_r;
         default:         raw_tick = !sleeping;
      endcase
   end

   // prescaler output on the 1/2/4/8 boundary
   function ps_hit;
      input [1:0] sel;
      input [2:0] cnt;
      case (sel)
         2'h0:    ps_hit = 1'b1;
         2'h1:    ps_hit = cnt[0];
         2'h2:    ps_hit = &cnt[1:0];
         default: ps_hit = &cnt;
      endcase
   endfunction

   wire ps_tick = count_en && raw_tick && ps_hit(ps_sel, ps_r);

   // synchronised path adds one stage; it stops in sleep
   wire use_sync = is_ext && !bypass;
   wire inc = use_sync ? (sync_tick_r && !sleeping) :
                         (ps_tick && !use_sync);

   // ************************************************************
   // counter, prescaler, edge arming
   // ************************************************************
   wire [CNT_W-1:0] cnt_inc = cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};

   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_r       <= {CNT_W{1'b0}};
         ps_r        <= 3'h0;
         div_r       <= 2'h0;
         armed_r     <= 1'b0;
         ext_d_r     <= 1'b0;
         sync_tick_r <= 1'b0;
         OVERFLOW    <= 1'b0;
         hbuf_r      <= `TCSO_RST_BYTE;
      end else begin
         ext_d_r     <= ext_lvl;
         div_r       <= div_r + 2'h1;
         sync_tick_r <= use_sync && ps_tick && !sleeping;
         OVERFLOW    <= 1'b0;
         if (count_en && raw_tick)
            ps_r <= ps_r + 3'h1;
         // arm on a falling edge; disarm on disable or any count write
         if (!run_on || wr_low || wr_high)
            armed_r <= 1'b0;
         else if (ext_fall)
            armed_r <= 1'b1;
         if (rd_low)
            hbuf_r <= cnt_r[15:8];
         if (wr_high && wide)
            hbuf_r <= WDATA;
         // software writes win over a coincident increment
         if (wr_low) begin
            cnt_r[7:0] <= WDATA;
            ps_r       <= 3'h0;
            if (wide)
               cnt_r[15:8] <= hbuf_r;
         end else if (wr_high) begin
            if (!wide)
               cnt_r[15:8] <= WDATA;
         end else if (inc) begin
            cnt_r    <= cnt_inc;
            OVERFLOW <= &cnt_r;
         end
      end
   end

   // ************************************************************
   // control registers
   // ************************************************************
   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r     <= `TCSO_RST_BYTE;
         gate_r     <= `TCSO_RST_BYTE;
         comp_r     <= `TCSO_RST_BYTE;
         osc_r      <= `TCSO_RST_BYTE;
         warmup_r   <= 1'b0;
         dir_r      <= `TCSO_RST_DIR;
         PORT_C_OUT <= 2'h0;
      end else if (WR) begin
         case (ADDR)
            `TCSO_A_CTRL: ctrl_r <= WDATA;
            `TCSO_A_GATE: gate_r <= WDATA;
            `TCSO_A_COMP: comp_r <= WDATA;
            `TCSO_A_OSC:  osc_r  <= WDATA;
            `TCSO_A_OSC2: warmup_r <= WDATA[`TCSO_B_WARMUP];
            `TCSO_A_PORT: begin
               dir_r      <= WDATA[1:0];
               PORT_C_OUT <= WDATA[5:4];
            end
            default: ;
         endcase
      end
   end

   // ************************************************************
   // power-managed modes and running flag
   // ************************************************************
   wire sec_sel = (system_clock_select == `TCSO_SCS_SEC) && !fs_s_r[1];

   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         IN_SLEEP            <= 1'b0;
         SECONDARY_IDLE_MODE <= 1'b0;
         SECONDARY_RUN_MODE  <= 1'b0;
         SEC_CLOCK_RUNNING   <= 1'b0;
      end else begin
         SEC_CLOCK_RUNNING <= sec_sel && SEC_OSC_ENABLE;
         if (WAKE) begin
            IN_SLEEP            <= 1'b0;
            SECONDARY_IDLE_MODE <= 1'b0;
         end else if (SLEEP_EXEC && !sleeping) begin
            if (sec_sel && !osc_r[`TCSO_B_IDLE])
               SECONDARY_IDLE_MODE <= 1'b1;
            else
               IN_SLEEP <= 1'b1;
         end
         SECONDARY_RUN_MODE <= sec_sel && !sleeping &&
                               !(SLEEP_EXEC && !WAKE);
      end
   end

   // ************************************************************
   // read port
   // ************************************************************
   wire [1:0] pins = crystal ? 2'h0 : {pc1_s_r[1], pc0_s_r[1]};

   always @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         RDATA <= `TCSO_RST_BYTE;
      end else if (RD) begin
         case (ADDR)
            `TCSO_A_CTRL: RDATA <= ctrl_r;
            `TCSO_A_GATE: RDATA <= gate_r;
            `TCSO_A_LOW:  RDATA <= cnt_r[7:0];
            `TCSO_A_HIGH: RDATA <= wide ? hbuf_r : cnt_r[15:8];
            `TCSO_A_COMP: RDATA <= comp_r;
            `TCSO_A_OSC:  RDATA <= osc_r;
            `TCSO_A_OSC2: RDATA <= {1'b0, SEC_CLOCK_RUNNING, 2'h0,
                                    warmup_r, 3'h0};
            `TCSO_A_PORT: RDATA <= {pins, PORT_C_OUT, 2'h0, dir_r};
            default:      RDATA <= 8'h00;
         endcase
      end else begin
         RDATA <= 8'h00;
      end
   end

endmodule // tcso_timer

/* tcso_timer_monitor.sv */
// Purpose: port-level assertions for tcso_timer
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to the design from the testbench top file
`timescale 1ns/1ps
`include "tcso_defs.vh"
module tcso_timer_monitor (
   input wire       CLOCK,
   input wire       RESETN,
   input wire [2:0] ADDR,
   input wire [7:0] WDATA,
   input wire       WR,
   input wire       RD,
   input wire [7:0] RDATA,
   input wire       CRYSTAL_MODE,
   input wire       SLEEP_EXEC,
   input wire       WAKE,
   input wire [1:0] PORT_C_OE_N,
   input wire       SEC_OSC_ENABLE,
   input wire       SEC_CLOCK_RUNNING,
   input wire       SECONDARY_RUN_MODE,
   input wire       SECONDARY_IDLE_MODE,
   input wire       IN_SLEEP,
   input wire       OVERFLOW
);
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);
   // **********
   // properties
   // **********
   sequence s_crystal;
      CRYSTAL_MODE [*4];
   endsequence
   sequence s_sleep_run;
      SECONDARY_RUN_MODE && SLEEP_EXEC && !WAKE;
   endsequence
   a_oe_crystal: assert property (s_crystal |-> PORT_C_OE_N == 2'h3)
      else $error("oscillator pins driven in crystal mode");
   a_pin_read_zero: assert property (s_crystal ##0 (RD && ADDR == `TCSO_A_PORT) |=> RDATA[7:6] == 2'h0)
      else $error("oscillator pins not read as zero");
   a_ovf_single: assert property (OVERFLOW |=> !OVERFLOW)
      else $error("overflow pulse too long");
   a_osc_by_bit: assert property (WR && (ADDR == `TCSO_A_CTRL || ADDR == `TCSO_A_COMP) && WDATA[3] |=> SEC_OSC_ENABLE)
      else $error("enable bit did not start oscillator");
   a_osc_warmup: assert property (WR && ADDR == `TCSO_A_OSC2 && WDATA[3] |=> SEC_OSC_ENABLE)
      else $error("warm-up request did not start oscillator");
   a_osc_by_select: assert property (WR && ADDR == `TCSO_A_OSC && WDATA[1:0] == 2'h1 |=> SEC_OSC_ENABLE)
      else $error("clock select did not start oscillator");
   a_idle_entry: assert property (s_sleep_run |=> SECONDARY_IDLE_MODE ^ IN_SLEEP)
      else $error("sleep from secondary run gave no single mode");
   a_wake_clear: assert property (WAKE |=> !SECONDARY_IDLE_MODE && !IN_SLEEP)
      else $error("wake did not leave low-power mode");
   a_run_flag: assert property (SEC_CLOCK_RUNNING |-> $past(SEC_OSC_ENABLE))
      else $error("running flag without oscillator");
   a_run_mode: assert property (SECONDARY_RUN_MODE |-> $past(SEC_OSC_ENABLE))
      else $error("secondary run without oscillator");
endmodule // tcso_timer_monitor

/* tcso_ext_source.sv */
// Purpose: external count clock source
// Assumes: driven by testbench task calls
// Notes: line stands still at its idle level between bursts
`timescale 1ns/1ps
module tcso_ext_source (
   output logic pin
);
   initial pin = 1'h1;
   task set_idle(input bit hi);
      pin = hi;
   endtask
   // n rising edges, 100 ns period, ends at the idle level
   task burst(input int n);
      repeat (2 * n) begin
         #50;
         pin = ~pin;
      end
      #50;
   endtask
endmodule // tcso_ext_source

/* tcso_timer_test.sv */
// Purpose: self-checking bench for tcso_timer
// Assumes: 40 MHz clock, one-cycle register port
// Notes: count rates measured as deltas over 16 cycles
`timescale 1ns/1ps
`include "tcso_defs.vh"
module tcso_timer_test;
   reg         clk, rst_n, wr, rd, gate, xtal, slp, wake, fs;
   reg  [2:0]  addr;
   reg  [7:0]  wdata, a, b;
   reg  [1:0]  pin;
   reg  [31:0] t;
   wire [7:0]  rdata;
   wire [1:0]  pout, oe_n;
   wire        ext, osc_clk, osc_en, running, secondary_run_mode, secondary_idle_mode, sleeping, ovf;
   integer     num_errors, n_tests, i, k;
   tcso_ext_source i_src (.pin(ext));
   tcso_ext_source i_osc (.pin(osc_clk));
   tcso_timer i_dut (.CLOCK(clk), .RESETN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .EXT_COUNT_IN(ext), .SEC_OSC_CLK_IN(osc_clk), .GATE_IN(gate),
      .CRYSTAL_MODE(xtal), .SLEEP_EXEC(slp), .WAKE(wake), .FAILSAFE(fs), .PORT_C_IN(pin),
      .PORT_C_OUT(pout), .PORT_C_OE_N(oe_n), .SEC_OSC_ENABLE(osc_en),
      .SEC_CLOCK_RUNNING(running), .SECONDARY_RUN_MODE(secondary_run_mode),
      .SECONDARY_IDLE_MODE(secondary_idle_mode), .IN_SLEEP(sleeping), .OVERFLOW(ovf));
   // *****
   // tasks
   // *****
   task wr_reg(input [2:0] ad, input [7:0] d);
      @(posedge clk);
      addr <= ad;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
      #1;
   endtask
   task rd_reg(input [2:0] ad, output [7:0] d);
      @(posedge clk);
      addr <= ad;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1 d = rdata;
   endtask
   task pulse(input bit w);
      @(posedge clk);
      if (w) wake <= 1'h1;
      else slp <= 1'h1;
      @(posedge clk);
      wake <= 1'h0;
      slp <= 1'h0;
      @(posedge clk);
      #1;
   endtask
   task chk(input [7:0] got, input [7:0] exp);
      n_tests = n_tests + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task stop_test;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      {rst_n, wr, rd, gate, xtal, slp, wake, fs} = 8'h00;
      addr = 3'h0;
      wdata = 8'h00;
      pin = 2'h3;
      num_errors = 0;
      n_tests = 0;
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      for (i = 0; i < 8; i++) begin
         rd_reg(i[2:0], a);
         chk(a, (i == 7) ? 8'hC3 : 8'h00);
      end
      chk(oe_n, 8'h03);
      $display("reset values done");
      for (i = 0; i < 8; i++) begin
         t = (i == 0) ? 32'h4100_0010 : (i == 1) ? 32'h5100_0008 : (i == 2) ? 32'h6100_0004 :
             (i == 3) ? 32'h7100_0002 : (i == 4) ? 32'h0100_0004 : (i == 5) ? 32'h4000_0000 :
             (i == 6) ? 32'h4180_0100 : 32'h41C0_0110;
         @(posedge clk) gate <= t[8];
         wr_reg(`TCSO_A_GATE, t[23:16]);
         wr_reg(`TCSO_A_CTRL, t[31:24]);
         repeat (4) @(posedge clk);
         rd_reg(`TCSO_A_LOW, a);
         repeat (14) @(posedge clk);
         rd_reg(`TCSO_A_LOW, b);
         chk(b - a, t[7:0]);
      end
      wr_reg(`TCSO_A_GATE, 8'h00);
      $display("rates done");
      wr_reg(`TCSO_A_CTRL, 8'h71);
      wr_reg(`TCSO_A_LOW, 8'h00);
      wr_reg(`TCSO_A_HIGH, 8'h00);
      repeat (4) @(posedge clk);
      rd_reg(`TCSO_A_LOW, a);
      chk(a, 8'h00);
      rd_reg(`TCSO_A_LOW, b);
      chk(b, 8'h01);
      wr_reg(`TCSO_A_CTRL, 8'h02);
      wr_reg(`TCSO_A_HIGH, 8'hAB);
      rd_reg(`TCSO_A_HIGH, a);
      chk(a, 8'hAB);
      wr_reg(`TCSO_A_LOW, 8'hCD);
      wr_reg(`TCSO_A_HIGH, 8'h11);
      wr_reg(`TCSO_A_CTRL, 8'h00);
      rd_reg(`TCSO_A_HIGH, a);
      chk(a, 8'hAB);
      rd_reg(`TCSO_A_LOW, a);
      chk(a, 8'hCD);
      wr_reg(`TCSO_A_HIGH, 8'h5A);
      rd_reg(`TCSO_A_HIGH, a);
      chk(a, 8'h5A);
      wr_reg(`TCSO_A_CTRL, 8'h02);
      rd_reg(`TCSO_A_LOW, a);
      rd_reg(`TCSO_A_HIGH, b);
      chk(a, 8'hCD);
      chk(b, 8'h5A);
      wr_reg(`TCSO_A_CTRL, 8'h00);
      wr_reg(`TCSO_A_HIGH, 8'hFF);
      wr_reg(`TCSO_A_LOW, 8'hF0);
      wr_reg(`TCSO_A_CTRL, 8'h41);
      for (k = 0; k < 40 && ovf !== 1'h1; k++) @(posedge clk) #1;
      if (k == 40) begin
         num_errors = num_errors + 1;
         stop_test;
      end
      wr_reg(`TCSO_A_CTRL, 8'h40);
      rd_reg(`TCSO_A_HIGH, a);
      chk(a, 8'h00);
      $display("byte access done");
      for (i = 0; i < 6; i++) begin
         t = (i == 0) ? 32'h8101_0005 : (i == 1) ? 32'h8500_0004 :
             (i == 2) ? 32'h8101_0100 : (i == 3) ? 32'h8501_0105 :
             (i == 4) ? 32'h8D03_0005 : 32'h8D01_0000;
         i_src.set_idle(t[16]);
         i_osc.set_idle(t[16]);
         wr_reg(`TCSO_A_CTRL, t[31:24]);
         repeat (8) @(posedge clk);
         wr_reg(`TCSO_A_LOW, 8'h00);
         if (t[8]) pulse(1'h0);
         if (t[17]) i_osc.burst(5);
         else i_src.burst(5);
         repeat (10) @(posedge clk);
         if (t[8]) begin
            chk(sleeping, 8'h01);
            pulse(1'h1);
         end
         rd_reg(`TCSO_A_LOW, a);
         chk(a, t[7:0]);
      end
      wr_reg(`TCSO_A_CTRL, 8'h00);
      $display("external count done");
      for (i = 0; i < 4; i++) begin
         t = (i == 0) ? 32'h0008 : (i == 1) ? 32'h0408 : (i == 2) ? 32'h0608 : 32'h0501;
         wr_reg(t[10:8], t[7:0]);
         chk(osc_en, 8'h01);
         wr_reg(t[10:8], 8'h00);
         chk(osc_en, 8'h00);
      end
      wr_reg(`TCSO_A_OSC, 8'h01);
      repeat (20) @(posedge clk); // start-up delay before use
      chk({running, secondary_run_mode}, 8'h03);
      rd_reg(`TCSO_A_OSC2, a);
      chk(a, 8'h40);
      pulse(1'h0);
      chk({secondary_idle_mode, sleeping, osc_en}, 8'h05);
      pulse(1'h1);
      @(posedge clk) fs <= 1'h1;
      repeat (5) @(posedge clk);
      #1 chk({running, secondary_run_mode}, 8'h00);
      @(posedge clk) fs <= 1'h0;
      wr_reg(`TCSO_A_OSC, 8'h81);
      pulse(1'h0);
      chk({secondary_idle_mode, sleeping}, 8'h01);
      pulse(1'h1);
      wr_reg(`TCSO_A_OSC, 8'h00);
      $display("oscillator done");
      wr_reg(`TCSO_A_PORT, 8'h30);
      chk({oe_n, pout}, 8'h03);
      rd_reg(`TCSO_A_PORT, a);
      chk(a, 8'hF0);
      @(posedge clk) xtal <= 1'h1;
      repeat (5) @(posedge clk);
      #1 chk(oe_n, 8'h03);
      rd_reg(`TCSO_A_PORT, a);
      chk(a & 8'hC0, 8'h00);
      $display("crystal pins done");
      stop_test;
   end
endmodule // tcso_timer_test
bind tcso_timer tcso_timer_monitor i_mon (.CLOCK(CLOCK), .RESETN(RESETN), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .CRYSTAL_MODE(CRYSTAL_MODE),
   .SLEEP_EXEC(SLEEP_EXEC), .WAKE(WAKE), .PORT_C_OE_N(PORT_C_OE_N),
   .SEC_OSC_ENABLE(SEC_OSC_ENABLE), .SEC_CLOCK_RUNNING(SEC_CLOCK_RUNNING),
   .SECONDARY_RUN_MODE(SECONDARY_RUN_MODE), .SECONDARY_IDLE_MODE(SECONDARY_IDLE_MODE),
   .IN_SLEEP(IN_SLEEP), .OVERFLOW(OVERFLOW));
